// >>> pkg/sucrb_defs.svh
// What this block does
// - Register 0x52 holds trim field a in bits 7:5 (reset 7) and trim b in 4:2 (reset 5).
// - The 16-bit open-loop count reads as low byte at 0x6e and high byte at 0x6f, reset zero.
// - Register 0x70 holds doubler filter select 7:5 (reset 0) and bias select 1:0 (reset 3).
// - Register 0x71 holds quadrupler filter select 7:5 (reset 3) and bias select 1:0 (reset 0).
// - Bit 6 of 0x72 picks the secondary source: 0 divided output, 1 raw oscillator.
// - Bits 5:4 of 0x72 pick one of four rising power levels, resetting to the highest, 3.
// - Bit 3 of 0x72 turns the secondary output on and resets to off.
// - Bit 2 of 0x73 asks to stop the ADC clock, but the ADC enable setting overrides it.
// - Register 0x73 resets to zero, bit 1 powers down the feedback divider, 7:3 read zero.
// - Bit 0 of 0x73 divides the lock detector count by 32, giving 32, 64, 128 or 256.
// - Bit 0 of read-only 0x7c shows the lock state, other bits zero, reset zero.
// - Register 0x72 resets to 0x32 with writable reserved bit 1 and zeros in 7, 2 and 0.
`ifndef SUCRB_DEFS_SVH
`define SUCRB_DEFS_SVH

// register offsets
`define SUCRB_ADDR_TRIM 8'h52
`define SUCRB_ADDR_CNT_LO 8'h6e
`define SUCRB_ADDR_CNT_HI 8'h6f
`define SUCRB_ADDR_DBL 8'h70
`define SUCRB_ADDR_QUAD 8'h71
`define SUCRB_ADDR_SEC 8'h72
`define SUCRB_ADDR_DIV 8'h73
`define SUCRB_ADDR_LOCK 8'h7c

// reset values
`define SUCRB_RST_TRIM 8'hf4
`define SUCRB_RST_DBL 8'h03
`define SUCRB_RST_QUAD 8'h60
`define SUCRB_RST_SEC 8'h32
`define SUCRB_RST_DIV 8'h00

// writable bit masks
`define SUCRB_WMASK_TRIM 8'hfc
`define SUCRB_WMASK_DBL 8'he3
`define SUCRB_WMASK_QUAD 8'he3
`define SUCRB_WMASK_SEC 8'h7a
`define SUCRB_WMASK_DIV 8'h07

// field positions
`define SUCRB_SEC_SRC_BIT 6
`define SUCRB_SEC_PWR_LSB 4
`define SUCRB_SEC_ON_BIT 3
`define SUCRB_SEC_CPL_BIT 1
`define SUCRB_DIV_ADC_BIT 2
`define SUCRB_DIV_PD_BIT 1
`define SUCRB_DIV_PRE_BIT 0

// lock detector count scaling
`define SUCRB_LD_BASE_CYC 14'h0400
`define SUCRB_LD_PRE_SHIFT 5

`endif

// >>> pkg/sucrb_pkg.sv
package sucrb_pkg;

  typedef logic [7:0] sucrb_byte_t;

  // register access request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sucrb_req_s;

  // configuration fields steering the analog side
  typedef struct packed {
    logic [2:0] osc_buffer_trim_a;
    logic [2:0] osc_buffer_trim_b;
    logic [2:0] doubler_filter_select;
    logic [1:0] doubler_bias_select;
    logic [2:0] quadrupler_filter_select;
    logic [1:0] quadrupler_bias_select;
    logic secondary_output_source;
    logic [1:0] secondary_output_power;
    logic secondary_output_on;
    logic coupled_osc_reserved;
    logic feedback_divider_powerdown;
    logic lockdet_count_prescale;
  } sucrb_cfg_s;

endpackage

// >>> rtl/sucrb_sync3.sv
`timescale 1ns/1ns
module sucrb_sync3 (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_srst,
  // asynchronous level in, filtered level out
  input wire logic i_async,
  output logic o_level
);

  logic [2:0] sh_reg;
  logic [2:0] sh_next;
  logic lvl_reg;
  logic lvl_next;

  // shift chain, level accepted once stages two and three agree
  always_comb begin
    sh_next = {sh_reg[1:0], i_async};
    lvl_next = (sh_reg[1] == sh_reg[2]) ? sh_reg[2] : lvl_reg;
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      sh_reg <= 3'h0;
      lvl_reg <= 1'h0;
    end else begin
      sh_reg <= sh_next;
      lvl_reg <= lvl_next;
    end
  end

  assign o_level = lvl_reg;

endmodule // sucrb_sync3

// >>> rtl/sucrb_lockdet_scale.sv
`timescale 1ns/1ns
`include "sucrb_defs.svh"
module sucrb_lockdet_scale (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_srst,
  // count selection and prescale
  input wire logic [1:0] i_sel,
  input wire logic i_prescale,
  // resulting lock detector count in cycles
  output logic [13:0] o_cycles
);

  logic [13:0] cyc_reg;
  logic [13:0] cyc_next;
  logic [13:0] base;

  // base count doubles per select step, prescale divides by 32
  always_comb begin
    base = `SUCRB_LD_BASE_CYC << i_sel;
    cyc_next = i_prescale ? (base >> `SUCRB_LD_PRE_SHIFT) : base;
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      cyc_reg <= `SUCRB_LD_BASE_CYC;
    end else begin
      cyc_reg <= cyc_next;
    end
  end

  assign o_cycles = cyc_reg;

endmodule // sucrb_lockdet_scale

// >>> rtl/sucrb_regbank.sv
`timescale 1ns/1ns
`include "sucrb_defs.svh"
module sucrb_regbank
  import sucrb_pkg::*;
(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_srst,
  // register access from the serial interface
  input wire sucrb_req_s i_req,
  output sucrb_byte_t o_reg_rdata,
  output logic o_reg_rvalid,
  // status from the analog side and lower registers
  input wire logic i_lock_detect,
  input wire logic [15:0] i_osc_count,
  input wire logic i_osc_count_toggle,
  input wire logic i_adc_enable,
  input wire logic [1:0] i_lockdet_count_select,
  // controls to the analog side
  output sucrb_cfg_s o_cfg,
  output logic o_adc_clk_off,
  output logic [13:0] o_lockdet_cycles
);

  // write merge keeping read-only bits
  function automatic sucrb_byte_t merge(input sucrb_byte_t old_v, input sucrb_byte_t new_v,
                                        input sucrb_byte_t mask);
    merge = (old_v & ~mask) | (new_v & mask);
  endfunction

  // address match for a write
  function automatic logic wr_hit(input sucrb_req_s r, input sucrb_byte_t a);
    wr_hit = r.wr && (r.addr == a);
  endfunction

  // control registers
  sucrb_byte_t trim_reg;
  sucrb_byte_t trim_next;
  sucrb_byte_t dbl_reg;
  sucrb_byte_t dbl_next;
  sucrb_byte_t quad_reg;
  sucrb_byte_t quad_next;
  sucrb_byte_t sec_reg;
  sucrb_byte_t sec_next;
  sucrb_byte_t div_reg;
  sucrb_byte_t div_next;
  logic adc_off_reg;
  logic adc_off_next;

  // status registers
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic tog_seen_reg;
  logic tog_seen_next;
  logic lock_sync;
  logic tog_sync;

  // read port
  sucrb_byte_t rdata_reg;
  sucrb_byte_t rdata_next;
  logic rvalid_reg;
  logic rvalid_next;

  // filtered lock pin
  sucrb_sync3 u_lock_sync (
    .i_sys_clk(i_sys_clk),
    .i_srst(i_srst),
    .i_async(i_lock_detect),
    .o_level(lock_sync)
  );

  // filtered count-ready toggle
  sucrb_sync3 u_tog_sync (
    .i_sys_clk(i_sys_clk),
    .i_srst(i_srst),
    .i_async(i_osc_count_toggle),
    .o_level(tog_sync)
  );

  // lock detector cycle count
  sucrb_lockdet_scale u_ld_scale (
    .i_sys_clk(i_sys_clk),
    .i_srst(i_srst),
    .i_sel(i_lockdet_count_select),
    .i_prescale(div_reg[`SUCRB_DIV_PRE_BIT]),
    .o_cycles(o_lockdet_cycles)
  );

  // control register writes, read-only bits masked off
  always_comb begin
    trim_next = trim_reg;
    dbl_next = dbl_reg;
    quad_next = quad_reg;
    sec_next = sec_reg;
    div_next = div_reg;
    if (wr_hit(i_req, `SUCRB_ADDR_TRIM)) begin
      trim_next = merge(trim_reg, i_req.wdata, `SUCRB_WMASK_TRIM);
    end
    if (wr_hit(i_req, `SUCRB_ADDR_DBL)) begin
      dbl_next = merge(dbl_reg, i_req.wdata, `SUCRB_WMASK_DBL);
    end
    if (wr_hit(i_req, `SUCRB_ADDR_QUAD)) begin
      quad_next = merge(quad_reg, i_req.wdata, `SUCRB_WMASK_QUAD);
    end
    if (wr_hit(i_req, `SUCRB_ADDR_SEC)) begin
      sec_next = merge(sec_reg, i_req.wdata, `SUCRB_WMASK_SEC);
    end
    if (wr_hit(i_req, `SUCRB_ADDR_DIV)) begin
      div_next = merge(div_reg, i_req.wdata, `SUCRB_WMASK_DIV);
    end
    // adc enable wins over the disable request
    adc_off_next = div_next[`SUCRB_DIV_ADC_BIT] && !i_adc_enable;
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      trim_reg <= `SUCRB_RST_TRIM;
      dbl_reg <= `SUCRB_RST_DBL;
      quad_reg <= `SUCRB_RST_QUAD;
      sec_reg <= `SUCRB_RST_SEC;
      div_reg <= `SUCRB_RST_DIV;
      adc_off_reg <= 1'h0;
    end else begin
      trim_reg <= trim_next;
      dbl_reg <= dbl_next;
      quad_reg <= quad_next;
      sec_reg <= sec_next;
      div_reg <= div_next;
      adc_off_reg <= adc_off_next;
    end
  end

  // count capture on each toggle change, bus writes never reach it
  always_comb begin
    tog_seen_next = tog_sync;
    cnt_next = cnt_reg;
    if (tog_sync != tog_seen_reg) begin
      cnt_next = i_osc_count;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      cnt_reg <= 16'h0000;
      tog_seen_reg <= 1'h0;
    end else begin
      cnt_reg <= cnt_next;
      tog_seen_reg <= tog_seen_next;
    end
  end

  // read mux, unmapped offsets return zero
  always_comb begin
    rvalid_next = i_req.rd;
    rdata_next = rdata_reg;
    if (i_req.rd) begin
      case (i_req.addr)
        `SUCRB_ADDR_TRIM: rdata_next = trim_reg;
        `SUCRB_ADDR_CNT_LO: rdata_next = cnt_reg[7:0];
        `SUCRB_ADDR_CNT_HI: rdata_next = cnt_reg[15:8];
        `SUCRB_ADDR_DBL: rdata_next = dbl_reg;
        `SUCRB_ADDR_QUAD: rdata_next = quad_reg;
        `SUCRB_ADDR_SEC: rdata_next = sec_reg;
        `SUCRB_ADDR_DIV: rdata_next = div_reg;
        `SUCRB_ADDR_LOCK: rdata_next = {7'h00, lock_sync};
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'h0;
    end else begin
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  // outputs, all taken from register bits
  assign o_reg_rdata = rdata_reg;
  assign o_reg_rvalid = rvalid_reg;
  assign o_adc_clk_off = adc_off_reg;
  assign o_cfg.osc_buffer_trim_a = trim_reg[7:5];
  assign o_cfg.osc_buffer_trim_b = trim_reg[4:2];
  assign o_cfg.doubler_filter_select = dbl_reg[7:5];
  assign o_cfg.doubler_bias_select = dbl_reg[1:0];
  assign o_cfg.quadrupler_filter_select = quad_reg[7:5];
  assign o_cfg.quadrupler_bias_select = quad_reg[1:0];
  assign o_cfg.secondary_output_source = sec_reg[`SUCRB_SEC_SRC_BIT];
  assign o_cfg.secondary_output_power = sec_reg[`SUCRB_SEC_PWR_LSB +: 2];
  assign o_cfg.secondary_output_on = sec_reg[`SUCRB_SEC_ON_BIT];
  assign o_cfg.coupled_osc_reserved = sec_reg[`SUCRB_SEC_CPL_BIT];
  assign o_cfg.feedback_divider_powerdown = div_reg[`SUCRB_DIV_PD_BIT];
  assign o_cfg.lockdet_count_prescale = div_reg[`SUCRB_DIV_PRE_BIT];

  // checks on the register bank
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_srst);

  // a read request at a given offset
  sequence s_read(logic [7:0] a);
    i_req.rd && (i_req.addr == a);
  endsequence

  // a write request at a given offset
  sequence s_write(logic [7:0] a);
    i_req.wr && (i_req.addr == a);
  endsequence

  // trim fields come out of reset as 7 and 5
  property p_trim_reset;
    $past(i_srst) |-> (o_cfg.osc_buffer_trim_a == 3'h7) && (o_cfg.osc_buffer_trim_b == 3'h5);
  endproperty
  a_trim_reset: assert property (p_trim_reset) else $error("trim reset wrong");

  // trim write lands next cycle, low bits stay zero, then read back
  property p_trim_write;
    s_write(`SUCRB_ADDR_TRIM) ##0 (!i_req.rd) ##1 s_read(`SUCRB_ADDR_TRIM)
      |=> o_reg_rvalid && (o_reg_rdata == ($past(i_req.wdata, 2) & 8'hfc));
  endproperty
  a_trim_write: assert property (p_trim_write) else $error("trim write readback wrong");

  // count high byte reads back the captured count
  property p_cnt_read;
    s_read(`SUCRB_ADDR_CNT_HI) |=> o_reg_rvalid && (o_reg_rdata == $past(cnt_reg[15:8]));
  endproperty
  a_cnt_read: assert property (p_cnt_read) else $error("count high byte wrong");

  // a write to the count never changes it without a toggle
  property p_cnt_ro;
    (s_write(`SUCRB_ADDR_CNT_LO) or s_write(`SUCRB_ADDR_CNT_HI)) ##0 (tog_sync == tog_seen_reg)
      |=> $stable(cnt_reg);
  endproperty
  a_cnt_ro: assert property (p_cnt_ro) else $error("count changed by a write");

  // doubler register reset value
  property p_dbl_reset;
    $past(i_srst) |-> (o_cfg.doubler_filter_select == 3'h0) && (o_cfg.doubler_bias_select == 2'h3);
  endproperty
  a_dbl_reset: assert property (p_dbl_reset) else $error("doubler reset wrong");

  // quadrupler write places filter and bias fields
  property p_quad_write;
    s_write(`SUCRB_ADDR_QUAD) |=> (o_cfg.quadrupler_filter_select == $past(i_req.wdata[7:5]))
      && (o_cfg.quadrupler_bias_select == $past(i_req.wdata[1:0])) && (quad_reg[4:2] == 3'h0);
  endproperty
  a_quad_write: assert property (p_quad_write) else $error("quadrupler write wrong");

  // secondary register resets to 0x32, output off at highest power
  property p_sec_reset;
    $past(i_srst) |-> (sec_reg == 8'h32) && !o_cfg.secondary_output_on
      && (o_cfg.secondary_output_power == 2'h3) && !o_cfg.secondary_output_source;
  endproperty
  a_sec_reset: assert property (p_sec_reset) else $error("secondary reset wrong");

  // secondary write maps source, power and enable; reserved zeros stay zero
  property p_sec_write;
    s_write(`SUCRB_ADDR_SEC) |=> (o_cfg.secondary_output_source == $past(i_req.wdata[6]))
      && (o_cfg.secondary_output_power == $past(i_req.wdata[5:4]))
      && (o_cfg.secondary_output_on == $past(i_req.wdata[3]))
      && (sec_reg[7] == 1'h0) && (sec_reg[2] == 1'h0) && (sec_reg[0] == 1'h0);
  endproperty
  a_sec_write: assert property (p_sec_write) else $error("secondary write wrong");

  // adc clock stops only when requested and not overridden
  property p_adc_override;
    1'b1 |-> (o_adc_clk_off == (div_reg[`SUCRB_DIV_ADC_BIT] && !$past(i_adc_enable)));
  endproperty
  a_adc_override: assert property (p_adc_override) else $error("adc clock gate wrong");

  // divider register reserved bits read as zero
  property p_div_read;
    s_read(`SUCRB_ADDR_DIV) |=> o_reg_rvalid && (o_reg_rdata[7:3] == 5'h00)
      && (o_reg_rdata[2:0] == $past(div_reg[2:0]));
  endproperty
  a_div_read: assert property (p_div_read) else $error("divider register read wrong");

  // prescale set gives a count between 32 and 256 two cycles on
  property p_ld_prescale;
    (div_reg[`SUCRB_DIV_PRE_BIT] && $stable(i_lockdet_count_select)) [*2]
      |-> (o_lockdet_cycles == (14'h0020 << $past(i_lockdet_count_select)));
  endproperty
  a_ld_prescale: assert property (p_ld_prescale) else $error("lock count prescale wrong");

  // lock register shows the filtered lock level and zeros above
  property p_lock_read;
    s_read(`SUCRB_ADDR_LOCK) |=> o_reg_rvalid && (o_reg_rdata == {7'h00, $past(lock_sync)});
  endproperty
  a_lock_read: assert property (p_lock_read) else $error("lock readback wrong");

  // a stable lock pin reaches the readback within five cycles, also right after reset
  property p_lock_follow;
    $stable(i_lock_detect) [*5] |-> (lock_sync == i_lock_detect);
  endproperty
  a_lock_follow: assert property (p_lock_follow) else $error("lock level not followed");

  // unmapped offset 0x53 reads zero
  property p_unmapped;
    i_req.rd && (i_req.addr == 8'h53) |=> o_reg_rvalid && (o_reg_rdata == 8'h00);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  // read answer follows each read request by exactly one cycle
  property p_rvalid_pulse;
    !$past(i_srst) |-> (o_reg_rvalid == $past(i_req.rd));
  endproperty
  a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("read answer timing wrong");

  // doubler write places filter and bias fields, middle bits stay zero
  property p_dbl_write;
    s_write(`SUCRB_ADDR_DBL) |=> (o_cfg.doubler_filter_select == $past(i_req.wdata[7:5]))
      && (o_cfg.doubler_bias_select == $past(i_req.wdata[1:0])) && (dbl_reg[4:2] == 3'h0);
  endproperty
  a_dbl_write: assert property (p_dbl_write) else $error("doubler write wrong");

  // quadrupler register reset value
  property p_quad_reset;
    $past(i_srst) |-> (o_cfg.quadrupler_filter_select == 3'h3)
      && (o_cfg.quadrupler_bias_select == 2'h0);
  endproperty
  a_quad_reset: assert property (p_quad_reset) else $error("quadrupler reset wrong");

  // divider write places power-down and prescale, reserved bits stay zero
  property p_div_write;
    s_write(`SUCRB_ADDR_DIV) |=> (o_cfg.feedback_divider_powerdown == $past(i_req.wdata[1]))
      && (o_cfg.lockdet_count_prescale == $past(i_req.wdata[0])) && (div_reg[7:3] == 5'h00);
  endproperty
  a_div_write: assert property (p_div_write) else $error("divider write wrong");

  // divider register and adc clock gate come out of reset cleared, lock count at 1024
  property p_div_reset;
    $past(i_srst) |-> (div_reg == 8'h00) && !o_adc_clk_off && (o_lockdet_cycles == 14'h0400);
  endproperty
  a_div_reset: assert property (p_div_reset) else $error("divider reset wrong");

  // trim register low bits never take a written one
  property p_trim_ro;
    1'b1 |-> (trim_reg[1:0] == 2'h0);
  endproperty
  a_trim_ro: assert property (p_trim_ro) else $error("trim reserved bits set");

  // a seen toggle change captures the count word in the next cycle
  property p_cnt_capture;
    (tog_sync != tog_seen_reg) |=> (cnt_reg == $past(i_osc_count));
  endproperty
  a_cnt_capture: assert property (p_cnt_capture) else $error("count not captured");

endmodule // sucrb_regbank

// >>> test/sucrb_regbank_test.sv
`timescale 1ns/1ns
`include "sucrb_defs.svh"
module sucrb_regbank_test
  import sucrb_pkg::*;
;
  // clock and reset
  logic i_sys_clk;
  logic i_srst;
  // register port
  sucrb_req_s i_req;
  sucrb_byte_t o_reg_rdata;
  logic o_reg_rvalid;
  // status and controls
  logic i_lock_detect;
  logic [15:0] i_osc_count;
  logic i_osc_count_toggle;
  logic i_adc_enable;
  logic [1:0] i_lockdet_count_select;
  sucrb_cfg_s o_cfg;
  logic o_adc_clk_off;
  logic [13:0] o_lockdet_cycles;
  // bookkeeping
  int n_errors;
  int n_checks;
  int cyc;
  sucrb_cfg_s exp_cfg;

  // device under test
  sucrb_regbank sucrb_regbank_inst (
    .i_sys_clk(i_sys_clk),
    .i_srst(i_srst),
    .i_req(i_req),
    .o_reg_rdata(o_reg_rdata),
    .o_reg_rvalid(o_reg_rvalid),
    .i_lock_detect(i_lock_detect),
    .i_osc_count(i_osc_count),
    .i_osc_count_toggle(i_osc_count_toggle),
    .i_adc_enable(i_adc_enable),
    .i_lockdet_count_select(i_lockdet_count_select),
    .o_cfg(o_cfg),
    .o_adc_clk_off(o_adc_clk_off),
    .o_lockdet_cycles(o_lockdet_cycles)
  );

  // 250 mhz clock
  always #2 i_sys_clk = ~i_sys_clk;

  // hang guard, tests need under two hundred cycles
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_errors = n_errors + 1;
      $display("CHECK FAILED at %0t: timeout", $time);
      summarize();
    end
  end

  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // one write cycle, entered and left at a falling edge, request held until the next one
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge i_sys_clk);
  endtask

  // one read cycle, answer judged in the following cycle
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string msg);
    i_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge i_sys_clk);
    chk({31'h0, o_reg_rvalid}, 32'h1, "rvalid");
    chk({24'h0, o_reg_rdata}, {24'h0, exp}, msg);
  endtask

  // reset values of every register and control output
  task automatic test_reset();
    exp_cfg = '{3'h7, 3'h5, 3'h0, 2'h3, 3'h3, 2'h0, 1'b0, 2'h3, 1'b0, 1'b1, 1'b0, 1'b0};
    chk(o_cfg, exp_cfg, "cfg reset");
    chk({31'h0, o_adc_clk_off}, 32'h0, "adc off reset");
    chk({18'h0, o_lockdet_cycles}, 32'h400, "ld cycles reset");
    rd_chk(8'h52, 8'hf4, "trim reset");
    rd_chk(8'h6e, 8'h00, "cnt lo reset");
    rd_chk(8'h6f, 8'h00, "cnt hi reset");
    rd_chk(8'h70, 8'h03, "dbl reset");
    rd_chk(8'h71, 8'h60, "quad reset");
    rd_chk(8'h72, 8'h32, "sec reset");
    rd_chk(8'h73, 8'h00, "div reset");
    rd_chk(8'h7c, 8'h00, "lock reset");
    rd_chk(8'h53, 8'h00, "unmapped");
    $display("test_reset done");
  endtask

  // writable bits only, back to back accesses
  task automatic test_rw();
    logic [7:0] addrs [5];
    logic [7:0] masks [5];
    addrs = '{8'h52, 8'h70, 8'h71, 8'h72, 8'h73};
    masks = '{8'hfc, 8'he3, 8'he3, 8'h7a, 8'h07};
    for (int i = 0; i < 5; i++) begin
      wr(addrs[i], 8'hff);
      rd_chk(addrs[i], masks[i], "ones");
      wr(addrs[i], 8'h00);
      rd_chk(addrs[i], 8'h00, "zeros");
      wr(addrs[i], 8'ha5);
      rd_chk(addrs[i], 8'ha5 & masks[i], "pattern");
    end
    wr(8'h52, 8'ha8);
    chk(o_cfg.osc_buffer_trim_a, 32'h5, "trim a");
    chk(o_cfg.osc_buffer_trim_b, 32'h2, "trim b");
    wr(8'h70, 8'h41);
    chk({o_cfg.doubler_filter_select, o_cfg.doubler_bias_select}, 32'h09, "dbl");
    wr(8'h71, 8'hc2);
    chk({o_cfg.quadrupler_filter_select, o_cfg.quadrupler_bias_select}, 32'h1a, "quad");
    for (int p = 0; p < 4; p++) begin
      wr(8'h72, 8'h48 | 8'(p << 4));
      chk(o_cfg.secondary_output_power, p, "sec power");
      chk(o_cfg.secondary_output_source, 32'h1, "sec source");
      chk(o_cfg.secondary_output_on, 32'h1, "sec on");
      chk(o_cfg.coupled_osc_reserved, 32'h0, "coupled");
    end
    wr(8'h72, 8'h02);
    chk({o_cfg.secondary_output_source, o_cfg.secondary_output_on}, 32'h0, "sec off");
    wr(8'h73, 8'h03);
    chk(o_cfg.feedback_divider_powerdown, 32'h1, "div pd");
    chk(o_cfg.lockdet_count_prescale, 32'h1, "prescale");
    // write and read in one cycle returns the old value
    i_req = '{wr: 1'b1, rd: 1'b1, addr: 8'h73, wdata: 8'h02};
    @(negedge i_sys_clk);
    chk({24'h0, o_reg_rdata}, 32'h03, "rd old");
    rd_chk(8'h73, 8'h02, "rd new");
    wr(8'h73, 8'h00);
    $display("test_rw done");
  endtask

  // read-only places ignore writes
  task automatic test_ro();
    wr(8'h6e, 8'hff);
    wr(8'h6f, 8'hff);
    wr(8'h7c, 8'hff);
    wr(8'h53, 8'hff);
    rd_chk(8'h6e, 8'h00, "ro lo");
    rd_chk(8'h6f, 8'h00, "ro hi");
    rd_chk(8'h7c, 8'h00, "ro lock");
    rd_chk(8'h53, 8'h00, "ro unmapped");
    $display("test_ro done");
  endtask

  // adc enable overrides the clock disable request
  task automatic test_adc();
    wr(8'h73, 8'h04);
    @(negedge i_sys_clk);
    chk({31'h0, o_adc_clk_off}, 32'h1, "adc off");
    i_adc_enable = 1'b1;
    repeat (2) @(negedge i_sys_clk);
    chk({31'h0, o_adc_clk_off}, 32'h0, "adc override");
    i_adc_enable = 1'b0;
    wr(8'h73, 8'h00);
    @(negedge i_sys_clk);
    chk({31'h0, o_adc_clk_off}, 32'h0, "adc on");
    $display("test_adc done");
  endtask

  // every count select with and without prescale
  task automatic test_lockdet();
    for (int p = 0; p < 2; p++) begin
      wr(8'h73, 8'(p));
      for (int s = 0; s < 4; s++) begin
        i_lockdet_count_select = 2'(s);
        repeat (2) @(negedge i_sys_clk);
        chk({18'h0, o_lockdet_cycles}, (p == 1 ? 32 : 1024) << s, "ld cycles");
      end
    end
    wr(8'h73, 8'h00);
    i_lockdet_count_select = 2'h0;
    $display("test_lockdet done");
  endtask

  // lock level and count capture both directions
  task automatic test_status();
    i_lock_detect = 1'b1;
    repeat (8) @(negedge i_sys_clk);
    rd_chk(8'h7c, 8'h01, "locked");
    i_lock_detect = 1'b0;
    repeat (8) @(negedge i_sys_clk);
    rd_chk(8'h7c, 8'h00, "unlocked");
    i_osc_count = 16'ha55a;
    @(negedge i_sys_clk);
    i_osc_count_toggle = 1'b1;
    repeat (8) @(negedge i_sys_clk);
    rd_chk(8'h6e, 8'h5a, "cnt lo");
    rd_chk(8'h6f, 8'ha5, "cnt hi");
    i_osc_count = 16'h0ff0;
    @(negedge i_sys_clk);
    i_osc_count_toggle = 1'b0;
    repeat (8) @(negedge i_sys_clk);
    rd_chk(8'h6e, 8'hf0, "cnt lo 2");
    rd_chk(8'h6f, 8'h0f, "cnt hi 2");
    $display("test_status done");
  endtask

  // reset in mid-run brings written registers and the count back
  task automatic test_mid_reset();
    wr(8'h72, 8'h7a);
    wr(8'h52, 8'h00);
    i_req = '0;
    i_srst = 1'b1;
    repeat (3) @(negedge i_sys_clk);
    i_srst = 1'b0;
    chk(o_cfg, exp_cfg, "cfg after reset");
    rd_chk(8'h72, 8'h32, "sec after reset");
    rd_chk(8'h52, 8'hf4, "trim after reset");
    rd_chk(8'h6f, 8'h00, "cnt hi after reset");
    $display("test_mid_reset done");
  endtask

  // verdict and end of run
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    i_sys_clk = 1'b0;
    i_srst = 1'b1;
    i_req = '0;
    i_lock_detect = 1'b0;
    i_osc_count = 16'h0000;
    i_osc_count_toggle = 1'b0;
    i_adc_enable = 1'b0;
    i_lockdet_count_select = 2'h0;
    n_errors = 0;
    n_checks = 0;
    cyc = 0;
    repeat (3) @(negedge i_sys_clk);
    i_srst = 1'b0;
    test_reset();
    test_rw();
    test_ro();
    test_adc();
    test_lockdet();
    test_status();
    test_mid_reset();
    summarize();
  end
endmodule // sucrb_regbank_test
